// file: bench/adc_link_checker.sv
`timescale 1ns/10ps
// watches the link between converter and host
module adc_link_checker #(
  parameter int POWERUP_CYC = 4,
  parameter int CONV_CYC = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // link signals
  input wire logic convert_start_n,
  input wire logic busy,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  localparam int CONV_LO = CONV_CYC - 1;
  localparam int CONV_HI = CONV_CYC + 1;
  localparam int WAKE_MAX = POWERUP_CYC + 8;
  localparam int LATE_MIN = POWERUP_CYC + 3;
  int busy_cnt;
  int high_cnt;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  // length of the current busy period
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !busy) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  // length of the current high phase of the start line
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !convert_start_n) high_cnt <= 0;
    else high_cnt <= high_cnt + 1;
  end
  ////////////////////////////////////////
  sequence conv_begin;
    !busy ##[1:5] busy;
  endsequence
  sequence bus_idle;
    (chip_select_n && read_strobe_n) [*4];
  endsequence
  chk_busy_length: assert property (
    $fell(busy) |-> busy_cnt inside {[CONV_LO:CONV_HI]})
    else $error("busy period has the wrong length");
  chk_wake_convert: assert property (
    $fell(convert_start_n) && !busy |-> ##[1:WAKE_MAX] busy)
    else $error("no conversion after start fell");
  chk_late_start: assert property (
    $fell(convert_start_n) && !busy && high_cnt > LATE_MIN |-> conv_begin)
    else $error("late start edge did not start at once");
  chk_no_read_busy: assert property (
    busy |-> chip_select_n && read_strobe_n)
    else $error("read strobed while busy");
  chk_port_reset: assert property (
    $rose(busy) |-> !data_oe)
    else $error("data bus driven as busy rose");
  chk_oe_on_read: assert property (
    $fell(read_strobe_n) |-> ##[1:4] data_oe)
    else $error("data bus not driven during read");
  chk_oe_released: assert property (
    bus_idle |-> !data_oe)
    else $error("data bus driven while not selected");
  chk_data_stable: assert property (
    data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("data changed during a read");
endmodule : adc_link_checker

// file: bench/tb_adc_convert_control_parallel_read.sv
`timescale 1ns/10ps
// both ends joined; user sides driven by the bench
module tb_adc_convert_control_parallel_read;
  localparam int PWRUP = 4;
  localparam int CONV = 8;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go = 1'b0;
  logic pd = 1'b0;
  logic [7:0] code = 8'h00;
  logic powered, fast, ready, valid;
  logic [7:0] result;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] codes [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h80, 8'h01};
  logic [5:0] pd_seq = 6'b010011;
  adc_link_if link ();
  adc_device #(.POWERUP_CYC(PWRUP), .CONV_CYC(CONV)) i_adc_device (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link),
    .sample_code_i(code), .powered_o(powered), .fast_mode_o(fast));
  adc_host #(.PULSE_CYC(10)) i_adc_host (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link), .go_i(go),
    .power_down_i(pd), .ready_o(ready), .valid_o(valid), .result_o(result));
  adc_link_checker #(.POWERUP_CYC(PWRUP), .CONV_CYC(CONV)) i_checker (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .convert_start_n(link.convert_start_n), .busy(link.busy),
    .chip_select_n(link.chip_select_n), .read_strobe_n(link.read_strobe_n),
    .data_out(link.data_out), .data_oe(link.data_oe));
  ////////////////////////////////////////
  // clock generation
  always #25 clock_i = ~clock_i;
  ////////////////////////////////////////
  task check(input string what, input logic [7:0] seen,
             input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // one conversion and read in the given mode
  task convert(input logic mode_pd, input logic [7:0] c);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    code = c;
    pd = mode_pd;
    go = 1'b1;
    @(negedge clock_i);
    go = 1'b0;
    n = 0;
    while (valid !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    check("valid", {7'h00, valid}, 8'h01);
    check("result", result, c);
    check("powered", {7'h00, powered}, {7'h00, !mode_pd});
    check("fast mode", {7'h00, fast}, {7'h00, !mode_pd});
  endtask : convert
  ////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    results();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'b0;
    check("powered at reset", {7'h00, powered}, 8'h00);
    check("fast at reset", {7'h00, fast}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      convert(pd_seq[i], codes[i]);
      $display("test %0d done, code %h mode %b", i, codes[i], pd_seq[i]);
    end
    results();
  end
endmodule : tb_adc_convert_control_parallel_read

// file: src/adc_ctrl_map.svh
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// clock rate and derived cycle counts
`define CLK_PERIOD_NS 50
`define POWERUP_TIME_NS 1500
`define POWERUP_CYCLES ((`POWERUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 4500
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_GAP_NS 100
`define READ_GAP_CYCLES ((`READ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_WIDTH 8
`define CODE_STEPS 256

`endif

// file: src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    PWR_DOWN,
    PWR_UP,
    CONVERTING
  } pwr_state_type;

  typedef enum logic [1:0] {
    H_IDLE,
    H_START,
    H_WAIT,
    H_READ
  } host_state_type;
endpackage : adc_ctrl_pkg

// file: src/adc_device.sv
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"
////////////////////////////////////////////////////////////////////////////
// converter control end: watches the start line from the host, runs the
// power-up pulse, times each conversion and serves the parallel read port.
// the start line and the read strobes come from another chip, so each one
// passes two flip-flops before any logic looks at it; every edge therefore
// reaches the logic two cycles late, and the host must allow for that.
// busy, data_out and data_oe come straight from registers, so the host
// never sees a glitch on them while it samples.
// the block holds no register that software can reach; the host only
// sees the start line, busy and the read port.
// the analog core is outside this block: sample_code_i stands for the
// code that the core has settled on by the last conversion cycle.
////////////////////////////////////////////////////////////////////////////
module adc_device #(
  parameter int POWERUP_CYC = `POWERUP_CYCLES,
  parameter int CONV_CYC = `CONV_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // link to host
  adc_link_if.device link,
  // analog side: sample code, status
  input wire logic [7:0] sample_code_i,
  output logic powered_o,
  output logic fast_mode_o
);
  localparam int CW = $clog2(CONV_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // the start line resets to low, its required level at power-on, so no
  // false rising edge follows reset; the strobes reset to their idle high.
  // only the second stage of each pair is read by the logic below.
  logic [1:0] cs_sync_r, cs_n_sync_r, rd_n_sync_r;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cs_sync_r <= 2'h0; // start low at power-on
      cs_n_sync_r <= 2'h3;
      rd_n_sync_r <= 2'h3;
    end else begin
      cs_sync_r <= {cs_sync_r[0], link.convert_start_n};
      cs_n_sync_r <= {cs_n_sync_r[0], link.chip_select_n};
      rd_n_sync_r <= {rd_n_sync_r[0], link.read_strobe_n};
    end
  end

  logic start_n, start_prev_r;
  assign start_n = cs_sync_r[1];
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      start_prev_r <= 1'b0;
    end else begin
      start_prev_r <= start_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal power-up pulse and gated start
  // a rising start edge always restarts the pulse, even from power-down,
  // so the core gets its full power-up time before the gated line falls.
  // the rise term covers the single cycle before the pulse counter loads,
  // so the gated line cannot dip low between the edge and the pulse.
  // the gated line falls at whichever of start and pulse ends later:
  // an early host edge waits for the pulse, a late one sets the instant.
  logic rise, pulse, gated_n, gated_prev_r, gated_fall;
  assign rise = start_n & ~start_prev_r;
  pulse_timer #(.COUNT(POWERUP_CYC)) u_pulse (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .trig_i(rise),
    .pulse_o(pulse)
  );
  assign gated_n = start_n | pulse | rise;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gated_prev_r <= 1'b0;
    end else begin
      gated_prev_r <= gated_n;
    end
  end
  // later of the two falling edges starts conversion
  assign gated_fall = gated_prev_r & ~gated_n;

  ////////////////////////////////////////////////////////////////////////////
  // power and conversion sequencing
  // PWR_DOWN: core unpowered, waits for a rising start edge.
  // PWR_UP: core powered, waits for the gated line to fall.
  // CONVERTING: busy high for a fixed count of cycles; start edges seen
  // here only restart the pulse, they never start a second conversion.
  // at the last conversion cycle the synced start level picks the mode:
  // high keeps the core powered for the next start (fast sampling),
  // low powers it down until the next rising edge (auto power-down).
  // the read port below does not depend on this state, so a stored
  // result can still be read while the core is powered down.
  adc_ctrl_pkg::pwr_state_type state_r;
  logic [CW-1:0] conv_cnt_r;
  logic busy_r, hold_r, fast_r, powered_r;
  logic [7:0] result_r;
  logic conv_done;
  assign conv_done = (state_r == adc_ctrl_pkg::CONVERTING) &&
                     (conv_cnt_r == CW'(1));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= adc_ctrl_pkg::PWR_DOWN;
      conv_cnt_r <= '0;
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      fast_r <= 1'b0;
      powered_r <= 1'b0;
      result_r <= 8'h00;
    end else begin
      case (state_r)
        adc_ctrl_pkg::PWR_DOWN: begin
          if (rise) begin
            powered_r <= 1'b1;
            state_r <= adc_ctrl_pkg::PWR_UP;
          end
        end
        adc_ctrl_pkg::PWR_UP: begin
          if (gated_fall) begin
            hold_r <= 1'b1;
            busy_r <= 1'b1;
            conv_cnt_r <= CW'(CONV_CYC);
            state_r <= adc_ctrl_pkg::CONVERTING;
          end
        end
        adc_ctrl_pkg::CONVERTING: begin
          // further start edges ignored here
          conv_cnt_r <= conv_cnt_r - 1'b1;
          if (conv_done) begin
            busy_r <= 1'b0;
            hold_r <= 1'b0;
            result_r <= sample_code_i;
            fast_r <= start_n;
            if (start_n) begin
              state_r <= adc_ctrl_pkg::PWR_UP;
            end else begin
              powered_r <= 1'b0;
              state_r <= adc_ctrl_pkg::PWR_DOWN;
            end
          end
        end
        default: begin
          state_r <= adc_ctrl_pkg::PWR_DOWN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel read port, independent of power state
  // the output register follows the stored result except while busy,
  // when the port is cleared, so a read during a conversion returns zero.
  // data_oe follows the strobe pins with a fixed lag of three edges;
  // the host must hold chip select and read low longer than that.
  logic [7:0] dout_r;
  logic oe_r;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end else if (busy_r) begin
      dout_r <= 8'h00;
      oe_r <= ~cs_n_sync_r[1] & ~rd_n_sync_r[1];
    end else begin
      oe_r <= ~cs_n_sync_r[1] & ~rd_n_sync_r[1];
      dout_r <= result_r;
    end
  end

  // every link output and status output is a register
  assign link.busy = busy_r;
  assign link.data_out = dout_r;
  assign link.data_oe = oe_r;
  assign powered_o = powered_r;
  assign fast_mode_o = fast_r;
endmodule : adc_device

// file: src/adc_host.sv
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"
// host: one request starts a conversion and reads the result
module adc_host #(
  parameter int GAP_CYC = `READ_GAP_CYCLES,
  parameter int PULSE_CYC = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // link to device
  adc_link_if.host link,
  // user side
  input wire logic go_i,
  input wire logic power_down_i,
  output logic ready_o,
  output logic valid_o,
  output logic [7:0] result_o
);
  localparam int PW = 8;

  ////////////////////////////////////////////////////////////////////////////
  // busy / data synchronisers
  logic [1:0] busy_sync_r;
  logic [7:0] d1_r, d2_r;
  logic busy_prev_r;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      busy_sync_r <= 2'h0;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
      busy_prev_r <= 1'b0;
    end else begin
      busy_sync_r <= {busy_sync_r[0], link.busy};
      d1_r <= link.data_out;
      d2_r <= d1_r;
      busy_prev_r <= busy_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  adc_ctrl_pkg::host_state_type st_r;
  logic [PW-1:0] cnt_r;
  logic start_n_r, cs_n_r, rd_n_r, pd_r, valid_r, ready_r;
  logic [7:0] res_r;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= adc_ctrl_pkg::H_IDLE;
      cnt_r <= '0;
      start_n_r <= 1'b0; // start held low from power-on
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      pd_r <= 1'b0;
      valid_r <= 1'b0;
      ready_r <= 1'b1;
      res_r <= 8'h00;
    end else begin
      valid_r <= 1'b0;
      case (st_r)
        adc_ctrl_pkg::H_IDLE: begin
          if (go_i) begin
            pd_r <= power_down_i;
            ready_r <= 1'b0;
            start_n_r <= 1'b1; // rising edge wakes the device
            cnt_r <= PW'(PULSE_CYC);
            st_r <= adc_ctrl_pkg::H_START;
          end
        end
        adc_ctrl_pkg::H_START: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == PW'(1)) begin
            start_n_r <= 1'b0; // falling edge: sample
            st_r <= adc_ctrl_pkg::H_WAIT;
          end
        end
        adc_ctrl_pkg::H_WAIT: begin
          // fast mode: raise start before end; power-down: keep low
          if (busy_sync_r[1]) begin
            start_n_r <= ~pd_r;
          end
          if (busy_prev_r & ~busy_sync_r[1]) begin
            cs_n_r <= 1'b0;
            rd_n_r <= 1'b0;
            cnt_r <= PW'(6);
            st_r <= adc_ctrl_pkg::H_READ;
          end
        end
        adc_ctrl_pkg::H_READ: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == PW'(1)) begin
            res_r <= d2_r;
            valid_r <= 1'b1;
            cs_n_r <= 1'b1; // start keeps its level until next go
            rd_n_r <= 1'b1;
            ready_r <= 1'b1;
            st_r <= adc_ctrl_pkg::H_IDLE;
          end
        end
        default: begin
          st_r <= adc_ctrl_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.convert_start_n = start_n_r;
  assign link.chip_select_n = cs_n_r;
  assign link.read_strobe_n = rd_n_r;
  assign ready_o = ready_r;
  assign valid_o = valid_r;
  assign result_o = res_r;
endmodule : adc_host

// file: src/adc_link_if.sv
`timescale 1ns/10ps
interface adc_link_if;
  logic convert_start_n;
  logic busy;
  logic chip_select_n;
  logic read_strobe_n;
  logic [7:0] data_out;
  logic data_oe;

  modport device (
    input convert_start_n, chip_select_n, read_strobe_n,
    output busy, data_out, data_oe
  );
  modport host (
    output convert_start_n, chip_select_n, read_strobe_n,
    input busy, data_out, data_oe
  );
endinterface : adc_link_if

// file: src/pulse_timer.sv
`timescale 1ns/10ps
// one-shot: holds pulse_o high for COUNT cycles after trig_i
module pulse_timer #(
  parameter int COUNT = 30
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // trigger and pulse
  input wire logic trig_i,
  output logic pulse_o
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_r;

  // down counter, restarted by each trigger
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else if (trig_i) begin
      cnt_r <= CW'(COUNT);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign pulse_o = (cnt_r != '0);
endmodule : pulse_timer
